// [nvsc_pkg.sv]
// Purpose: shared constants and types for the nvsram host controller
// Assumes: 100 MHz clock, slowest speed grade of the memory
// Notes: cycle counts derive from printed times and the clock period
package nvsc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 20;
    // least times, rounded up to whole cycles
    localparam int unsigned RD_ACCESS_NS = 45;
    localparam int unsigned WR_PULSE_NS = 30;
    localparam int unsigned STORE_INIT_NS = 20;
    localparam int unsigned RECALL_INIT_NS = 20;
    localparam int unsigned STORE_MS = 10;
    localparam int unsigned RECALL_US = 20;
    localparam int unsigned RESTORE_US = 550;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned RD_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RD_ACT_CYC = RD_CYC + SYNC_STAGES;
    localparam int unsigned WR_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STORE_INIT_CYC = (STORE_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECALL_INIT_CYC = (RECALL_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STORE_CYC = (STORE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECALL_CYC = (RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESTORE_CYC = (RESTORE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset values
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;

    typedef enum logic [1:0] {
        NVSC_OP_READ,
        NVSC_OP_WRITE,
        NVSC_OP_STORE,
        NVSC_OP_RECALL
    } nvsc_op_t;

    typedef struct packed {
        nvsc_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvsc_cmd_t;

    // active-low strobes toward the memory
    typedef struct packed {
        logic chip_sel_n;
        logic write_n;
        logic out_en_n;
        logic nonvolatile_select_n;
    } nvsc_strobe_t;

    localparam nvsc_strobe_t STROBE_IDLE = 4'hF;
endpackage

// [nvsc_sync.sv]
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: bits are independent levels
// Notes: first stage feeds only the second stage
module nvsc_sync #(
    parameter int unsigned W = 8
) (
    input wire logic mclk_i, // system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic [W-1:0] d_i, // asynchronous input
    output logic [W-1:0] q_o // synchronised output
);
    import nvsc_pkg::*;
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // one pair of flops per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= d_i[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end
    assign q_o = sync_q;
endmodule

// [nvsc_host.sv]
// Purpose: host controller driving a 512x8 nonvolatile static ram by its pins
// Assumes: single clock; memory pins are asynchronous to it
// Notes: one command at a time; store and recall are waited out by time
// How it works
// - write strobe high reading, low writing
// - nonvolatile select high in plain accesses
// - hold store combination at least 20 ns
// - store initiation ends by releasing strobes
module nvsc_host #(
    parameter int unsigned STORE_WAIT = nvsc_pkg::STORE_CYC, // store wait in cycles
    parameter int unsigned RESTORE_WAIT = nvsc_pkg::RESTORE_CYC // power-up recall wait
) (
    input wire logic mclk_i, // system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic cmd_valid_i, // command offered
    input wire nvsc_pkg::nvsc_cmd_t cmd_i, // op, address, write data
    output logic cmd_ready_o, // command taken when valid
    output logic [nvsc_pkg::DATA_W-1:0] rdata_o, // last read byte
    output logic done_o, // one-cycle pulse at op end
    output nvsc_pkg::nvsc_strobe_t strobe_o, // active-low memory strobes
    output logic [nvsc_pkg::ADDR_W-1:0] addr_o, // memory address
    input wire logic [nvsc_pkg::DATA_W-1:0] data_lines_i, // data pins in
    output logic [nvsc_pkg::DATA_W-1:0] data_lines_o, // data pins out
    output logic data_lines_oe_o // high while host drives data
);
    import nvsc_pkg::*;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_IDLE,
        ST_SETUP,
        ST_ACT,
        ST_WAIT,
        ST_REL
    } nvsc_state_t;

    localparam logic [CNT_W-1:0] RESTORE_LAST = CNT_W'(RESTORE_WAIT - 1);
    localparam logic [CNT_W-1:0] STORE_LAST = CNT_W'(STORE_WAIT - 1);
    localparam logic [CNT_W-1:0] RECALL_LAST = CNT_W'(RECALL_CYC - 1);
    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_ACT_CYC - 1);
    localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_CYC - 1);
    localparam logic [CNT_W-1:0] STORE_INIT_LAST = CNT_W'(STORE_INIT_CYC - 1);
    localparam logic [CNT_W-1:0] RECALL_INIT_LAST = CNT_W'(RECALL_INIT_CYC - 1);

    nvsc_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    nvsc_cmd_t cmd_q, cmd_d;
    nvsc_strobe_t strobe_q, strobe_d;
    logic oe_q, oe_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic done_q, done_d;
    logic [DATA_W-1:0] data_sync;
    logic nv_op;
    logic [CNT_W-1:0] act_last;

    // data pins pass two flops before use
    nvsc_sync #(.W(DATA_W)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(data_lines_i),
        .q_o(data_sync)
    );

    assign nv_op = (cmd_q.op == NVSC_OP_STORE) || (cmd_q.op == NVSC_OP_RECALL);

    // length of the asserted phase per operation
    always_comb begin
        case (cmd_q.op)
            NVSC_OP_READ: act_last = RD_LAST;
            NVSC_OP_WRITE: act_last = WR_LAST;
            NVSC_OP_STORE: act_last = STORE_INIT_LAST;
            default: act_last = RECALL_INIT_LAST;
        endcase
    end

    // sequencer next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        strobe_d = strobe_q;
        oe_d = oe_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        case (state_q)
            ST_BOOT: begin
                if (cnt_q == RESTORE_LAST) begin
                    state_d = ST_IDLE;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_IDLE: begin
                if (cmd_valid_i) begin
                    cmd_d = cmd_i;
                    state_d = ST_SETUP;
                    if ((cmd_i.op == NVSC_OP_STORE) || (cmd_i.op == NVSC_OP_RECALL)) begin
                        strobe_d = '{chip_sel_n: 1'b0, write_n: 1'b1, out_en_n: 1'b1,
                                     nonvolatile_select_n: 1'b0};
                    end
                    oe_d = (cmd_i.op == NVSC_OP_WRITE);
                end
            end
            ST_SETUP: begin
                state_d = ST_ACT;
                cnt_d = '0;
                case (cmd_q.op)
                    NVSC_OP_READ: strobe_d = '{chip_sel_n: 1'b0, write_n: 1'b1, out_en_n: 1'b0,
                                               nonvolatile_select_n: 1'b1};
                    NVSC_OP_WRITE: strobe_d = '{chip_sel_n: 1'b0, write_n: 1'b0, out_en_n: 1'b1,
                                                nonvolatile_select_n: 1'b1};
                    NVSC_OP_STORE: strobe_d.write_n = 1'b0;
                    default: strobe_d.out_en_n = 1'b0;
                endcase
            end
            ST_ACT: begin
                if (cnt_q == act_last) begin
                    cnt_d = '0;
                    strobe_d = STROBE_IDLE;
                    if (cmd_q.op == NVSC_OP_READ) begin
                        rdata_d = data_sync;
                    end
                    state_d = nv_op ? ST_WAIT : ST_REL;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_WAIT: begin
                if (cnt_q == ((cmd_q.op == NVSC_OP_STORE) ? STORE_LAST : RECALL_LAST)) begin
                    cnt_d = '0;
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            // data hold after write, then bus released
            ST_REL: begin
                oe_d = 1'b0;
                state_d = ST_IDLE;
                done_d = 1'b1;
            end
            default: begin
                state_d = ST_IDLE;
                strobe_d = STROBE_IDLE;
                oe_d = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_BOOT;
            cnt_q <= '0;
            cmd_q <= '0;
            strobe_q <= STROBE_IDLE;
            oe_q <= 1'b0;
            rdata_q <= DATA_RST;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
            strobe_q <= strobe_d;
            oe_q <= oe_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
        end
    end

    // pin and user outputs
    assign cmd_ready_o = (state_q == ST_IDLE);
    assign rdata_o = rdata_q;
    assign done_o = done_q;
    assign strobe_o = strobe_q;
    assign addr_o = cmd_q.addr;
    assign data_lines_o = cmd_q.wdata;
    assign data_lines_oe_o = oe_q;

    // assertion helpers
    logic store_combo;
    assign store_combo = !strobe_q.chip_sel_n && !strobe_q.write_n && strobe_q.out_en_n
                         && !strobe_q.nonvolatile_select_n;

    sequence store_entry_s;
        store_combo && !$past(store_combo);
    endsequence

    sequence store_hold_s;
        store_combo [*2];
    endsequence

    read_we_high_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_q == ST_ACT && cmd_q.op == NVSC_OP_READ) |-> strobe_q.write_n && !strobe_q.out_en_n)
        else $error("write strobe low during read");

    write_we_low_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_q == ST_ACT && cmd_q.op == NVSC_OP_WRITE) |-> !strobe_q.write_n && data_lines_oe_o)
        else $error("write strobe high during write");

    plain_nv_high_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_q inside {ST_SETUP, ST_ACT, ST_REL} && !nv_op) |-> strobe_q.nonvolatile_select_n)
        else $error("nonvolatile select low in plain access");

    store_hold_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        store_entry_s |-> store_hold_s)
        else $error("store combination held under 20 ns");

    store_release_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        store_combo ##1 !store_combo |-> strobe_q.nonvolatile_select_n && state_q == ST_WAIT)
        else $error("store initiation not ended by release");

    store_float_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (state_q == ST_WAIT) |-> !data_lines_oe_o && strobe_q == STROBE_IDLE)
        else $error("host drives pins while store runs");
endmodule

// [nvsc_mem_model.sv]
// Purpose: behavioural model of the nonvolatile static ram beyond the host
// Assumes: strobes change only on mclk_i edges; supply always good
// Notes: short busy times stand in for the long store and recall times
module nvsc_mem_model #(
    parameter int unsigned STORE_T = 10, // store busy cycles
    parameter int unsigned RECALL_T = 8, // recall busy cycles
    parameter int unsigned RESTORE_T = 4 // power-up recall busy cycles
) (
    input wire logic mclk_i, // clock the strobes follow
    input wire logic nrst_i, // power-up, active low
    input wire nvsc_pkg::nvsc_strobe_t strobe_i, // active-low strobes
    input wire logic [nvsc_pkg::ADDR_W-1:0] addr_i, // address pins
    input wire logic [nvsc_pkg::DATA_W-1:0] data_lines_i, // resolved data wire
    output logic [nvsc_pkg::DATA_W-1:0] data_lines_o // data driven by memory
);
    timeunit 1ns;
    timeprecision 1ps;
    import nvsc_pkg::*;
    logic [DATA_W-1:0] sram [512];
    logic [DATA_W-1:0] nv [512];
    logic [DATA_W-1:0] last_q;
    nvsc_strobe_t prev_q;
    int busy_q;
    logic storing_q;
    logic supply_ok;
    logic rd, wr, st, rc;
    assign rd = strobe_i == 4'h5;
    assign wr = !strobe_i.chip_sel_n && !strobe_i.write_n && strobe_i.nonvolatile_select_n;
    assign st = strobe_i == 4'h2;
    assign rc = strobe_i == 4'h4;
    assign supply_ok = 1'b1;
    // lines carry the inverted last value unless a read while not busy drives them
    assign data_lines_o = (rd && busy_q == 0) ? sram[addr_i] : ~last_q;
    // nonvolatile contents present from power-up
    initial for (int i = 0; i < 512; i++) nv[i] = 8'(i) ^ 8'h96;
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 512; i++) sram[i] = nv[i];
            busy_q <= RESTORE_T;
            storing_q <= 1'b0;
            prev_q <= STROBE_IDLE;
            last_q <= 8'h00;
        end else begin
            prev_q <= strobe_i;
            last_q <= data_lines_o;
            if (busy_q != 0) busy_q <= busy_q - 1;
            if (rc && prev_q != 4'h4 && (busy_q == 0 || storing_q)) begin
                for (int i = 0; i < 512; i++) sram[i] = 8'h00;
                for (int i = 0; i < 512; i++) sram[i] = nv[i];
                busy_q <= RECALL_T;
                storing_q <= 1'b0;
            end else if (st && prev_q != 4'h2 && busy_q == 0 && supply_ok) begin
                for (int i = 0; i < 512; i++) nv[i] = sram[i];
                busy_q <= STORE_T;
                storing_q <= 1'b1;
            end else if (wr && busy_q == 0) begin
                sram[addr_i] = data_lines_i;
            end
            if (busy_q == 1) storing_q <= 1'b0;
        end
    end
endmodule

// [nvsc_host_bench.sv]
// Purpose: self-checking bench for the nvsram host controller
// Assumes: shortened store and power-up waits
// Notes: strobe values seen in each command are gathered into a mask
module nvsc_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import nvsc_pkg::*;
    localparam int unsigned SW = 20;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    nvsc_cmd_t cmd_i = '0;
    logic cmd_ready_o, done_o, data_lines_oe_o;
    logic [DATA_W-1:0] rdata_o, data_lines_o, mem_data;
    nvsc_strobe_t strobe_o;
    logic [ADDR_W-1:0] addr_o;
    wire logic [DATA_W-1:0] data_lines_i = data_lines_oe_o ? data_lines_o : mem_data;
    int num_errors = 0;
    int samples_checked = 0;
    logic [15:0] mask;
    int run, cyc;
    // free-running 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    nvsc_host #(.STORE_WAIT(SW), .RESTORE_WAIT(5)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rdata_o(rdata_o),
        .done_o(done_o), .strobe_o(strobe_o), .addr_o(addr_o), .data_lines_i(data_lines_i),
        .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o));
    nvsc_mem_model mem (.mclk_i(mclk_i), .nrst_i(nrst_i), .strobe_i(strobe_o), .addr_i(addr_o),
        .data_lines_i(data_lines_i), .data_lines_o(mem_data));
    // closing report
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // one command, strobes gathered until done
    task automatic op(input nvsc_op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        mask = '0;
        run = 0;
        cyc = 0;
        cmd_i = '{op: o, addr: a, wdata: d};
        cmd_valid_i = 1'b1;
        for (k = 0; k < 64 && cmd_ready_o !== 1'b1; k++) @(negedge mclk_i);
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        for (k = 0; k < SW + 2100 && done_o !== 1'b1; k++) begin
            mask[strobe_o] = 1'b1;
            if (strobe_o == 4'h2) run++;
            cyc++;
            @(negedge mclk_i);
        end
        if (done_o !== 1'b1) begin
            chk("done", 1, 0);
            tally_and_finish();
        end
    endtask
    task automatic t_rw();
        logic [ADDR_W-1:0] ad [3] = '{9'h000, 9'h1FF, 9'h0A5};
        logic [DATA_W-1:0] da [3] = '{8'h11, 8'hEE, 8'h5A};
        op(NVSC_OP_READ, 9'h100, 8'h00);
        chk("power-up recall data", 8'h96, rdata_o);
        for (int i = 0; i < 3; i++) begin
            op(NVSC_OP_WRITE, ad[i], da[i]);
            chk("write strobes", 16'h8008, mask);
        end
        for (int i = 0; i < 3; i++) begin
            op(NVSC_OP_READ, ad[i], 8'h00);
            chk("read strobes", 16'h8020, mask);
            chk("read data", da[i], rdata_o);
        end
        $display("test rw done");
    endtask
    task automatic t_nv();
        op(NVSC_OP_WRITE, 9'h012, 8'h3C);
        op(NVSC_OP_STORE, 9'h000, 8'h00);
        chk("store strobes", 16'h8044, mask);
        chk("store hold", 1, run >= STORE_INIT_CYC);
        chk("store wait", 1, cyc >= SW);
        op(NVSC_OP_WRITE, 9'h012, 8'hC3);
        op(NVSC_OP_READ, 9'h012, 8'h00);
        chk("sram after store", 8'hC3, rdata_o);
        op(NVSC_OP_RECALL, 9'h000, 8'h00);
        chk("recall strobes", 16'h8050, mask);
        op(NVSC_OP_READ, 9'h012, 8'h00);
        chk("recalled byte", 8'h3C, rdata_o);
        op(NVSC_OP_READ, 9'h1FF, 8'h00);
        chk("recalled top byte", 8'hEE, rdata_o);
        $display("test nv done");
    endtask
    // mid-run reset, power-up recall restores stored byte
    task automatic t_reset();
        op(NVSC_OP_WRITE, 9'h012, 8'h77);
        nrst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        chk("mid reset strobes", 4'hF, strobe_o);
        chk("mid reset ready", 0, cmd_ready_o);
        nrst_i = 1'b1;
        op(NVSC_OP_READ, 9'h012, 8'h00);
        chk("restored byte", 8'h3C, rdata_o);
        $display("test reset again done");
    endtask
    // reset, then the scenarios
    initial begin
        repeat (16) @(negedge mclk_i);
        chk("reset strobes", 4'hF, strobe_o);
        chk("reset drive", 0, data_lines_oe_o);
        chk("reset ready", 0, cmd_ready_o);
        nrst_i = 1'b1;
        $display("test reset done");
        t_rw();
        t_nv();
        t_reset();
        tally_and_finish();
    end
endmodule
